// ### rtl/udc_ctl.sv
// usb device control: transceiver control, deferred function address, bus reset and suspend
`timescale 1ns/100ps
`default_nettype none
`include "udc_defs.svh"
module udc_ctl (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       vbus_present,
  input  wire logic       dplus_level,
  input  wire logic       dminus_level,
  input  wire logic       bus_reset_det,
  input  wire logic       suspend_det,
  input  wire logic       transfer_end,
  output logic            pullup_dplus,
  output logic            pullup_dminus,
  output logic            transceiver_enable,
  output logic      [1:0] phy_test_select,
  output logic            suspend_mode,
  output logic      [6:0] match_address,
  output logic            fifo_flush,
  output logic      [3:0] ep_index,
  output logic            irq
);

  udc_pkg::udc_state_t s_q;
  udc_pkg::udc_state_t s_d;

  logic       wr_fa;
  logic       wr_xc;
  logic       wr_pw;
  logic       soft_rst;
  logic       in_bank_wr;
  logic       in_bank_rd;
  logic       bank_clr;
  logic       diff_rx;
  logic [7:0] bank_rdata;
  logic [2:0] bank_waddr;
  logic [2:0] bank_raddr;

  // register decode
  // the csr bank answers only inside its own window; elsewhere it stays quiet
  always_comb begin
    wr_fa      = reg_wr && (reg_addr == `UDC_OFS_FUNC_ADDR);
    wr_xc      = reg_wr && (reg_addr == `UDC_OFS_XCVR_CTRL);
    wr_pw      = reg_wr && (reg_addr == `UDC_OFS_POWER);
    soft_rst   = wr_pw && reg_wdata[`UDC_PW_BUSRST_BIT];
    in_bank_wr = reg_wr && (reg_addr >= `UDC_OFS_CSR_BASE)
                 && (reg_addr < `UDC_OFS_CSR_BASE + 8'(`UDC_CSR_COUNT));
    in_bank_rd = reg_rd && (reg_addr >= `UDC_OFS_CSR_BASE)
                 && (reg_addr < `UDC_OFS_CSR_BASE + 8'(`UDC_CSR_COUNT));
    bank_waddr = 3'(reg_addr - `UDC_OFS_CSR_BASE);
    bank_raddr = 3'(reg_addr - `UDC_OFS_CSR_BASE);
    // differential receiver only meaningful while the transceiver runs
    diff_rx    = s_q.xcvr_en && dplus_level && !dminus_level;
  end

  assign bank_clr = bus_reset_det || soft_rst;

  udc_csr_bank #(
    .DEPTH (`UDC_CSR_COUNT),
    .AW    (3)
  ) u_csr_bank (
    .clk   (clk),
    .srst  (srst),
    .clr   (bank_clr),
    .wr    (in_bank_wr && !bank_clr),
    .waddr (bank_waddr),
    .wdata (reg_wdata),
    .raddr (bank_raddr),
    .rdata (bank_rdata)
  );

  always_comb begin
    s_d       = s_q;
    s_d.flush = 1'b0;
    s_d.rdata = 8'h00;

    // read data stand only in the cycle after the strobe
    s_d.bank_sel = in_bank_rd;
    // unmapped offsets read as zero
    if (reg_rd) begin
      if (reg_addr == `UDC_OFS_FUNC_ADDR) begin
        s_d.rdata = {s_q.pend, s_q.fa_wr};
      end else if (reg_addr == `UDC_OFS_POWER) begin
        s_d.rdata = {4'h0, s_q.rst_flag, 1'b0, s_q.susp_mode, s_q.susp_en};
      end else if (reg_addr == `UDC_OFS_INT_STS) begin
        s_d.rdata = {5'h00, s_q.int_sts};
      end else if (reg_addr == `UDC_OFS_INT_EN) begin
        s_d.rdata = {5'h00, s_q.int_en};
      end else if (reg_addr == `UDC_OFS_INDEX) begin
        s_d.rdata = {4'h0, s_q.index};
      end else if (reg_addr == `UDC_OFS_XCVR_CTRL) begin
        s_d.rdata = {s_q.pull_en, s_q.xcvr_en, s_q.speed, s_q.tst,
                     diff_rx, dplus_level, dminus_level};
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    if (soft_rst) begin
      // whole function back to defaults; the read result survives
      s_d.fa_wr     = 7'h00;
      s_d.pend      = 1'b0;
      s_d.fa_eff    = 7'h00;
      s_d.pull_en   = 1'b0;
      s_d.xcvr_en   = 1'b0;
      s_d.speed     = udc_pkg::UDC_LOW_SPEED;
      s_d.tst       = 2'h0;
      s_d.susp_en   = 1'b0;
      s_d.susp_mode = 1'b0;
      s_d.rst_flag  = 1'b0;
      s_d.int_sts   = 3'h0;
      s_d.int_en    = `UDC_INT_EN_RST;
      s_d.index     = 4'h0;
    end else begin
      if (wr_fa) begin
        s_d.fa_wr = reg_wdata[6:0];
        s_d.pend  = 1'b1;
      end else if (transfer_end && s_q.pend) begin
        // a write in the same cycle keeps the old address in force
        s_d.fa_eff = s_q.fa_wr;
        s_d.pend   = 1'b0;
      end
      if (wr_xc) begin
        s_d.pull_en = reg_wdata[`UDC_XC_PULLUP_BIT];
        s_d.xcvr_en = reg_wdata[`UDC_XC_XCVR_EN_BIT];
        s_d.speed   = udc_pkg::udc_speed_t'(reg_wdata[`UDC_XC_SPEED_BIT]);
        s_d.tst     = reg_wdata[`UDC_XC_TST_HI:`UDC_XC_TST_LO];
      end
      if (wr_pw) begin
        s_d.susp_en = reg_wdata[`UDC_PW_SUSP_EN_BIT];
      end
      if (reg_wr && reg_addr == `UDC_OFS_INT_STS) begin
        s_d.int_sts = s_q.int_sts & ~reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `UDC_OFS_INT_EN) begin
        s_d.int_en = reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `UDC_OFS_INDEX) begin
        s_d.index = reg_wdata[3:0];
      end
    end

    // events after software clears, so a coincident event is kept
    // a soft reset leaves every flag at its default unless a bus reset arrives in the same cycle
    if (transfer_end && !soft_rst) begin
      s_d.int_sts[`UDC_INT_XFER_BIT] = 1'b1;
    end
    if (suspend_det && s_q.susp_en && !soft_rst) begin
      s_d.susp_mode                  = 1'b1;
      s_d.int_sts[`UDC_INT_SUSP_BIT] = 1'b1;
    end

    // bus reset comes last: it overrides software and the other events
    if (bus_reset_det) begin
      s_d.rst_flag  = 1'b1;
      s_d.fa_wr     = 7'h00;
      s_d.fa_eff    = 7'h00;
      s_d.pend      = 1'b0;
      s_d.flush     = 1'b1;
      s_d.index     = 4'h0;
      s_d.int_en    = `UDC_INT_EN_BUSRST;
      s_d.int_sts   = 3'h0;
      s_d.susp_mode = 1'b0;
      s_d.int_sts[`UDC_INT_RST_BIT] = s_d.int_en[`UDC_INT_RST_BIT];
    end

    // pull-up sits on the line that the speed bit picks, only with bus power
    s_d.pu_dp = s_d.pull_en && vbus_present && (s_d.speed == udc_pkg::UDC_FULL_SPEED);
    s_d.pu_dm = s_d.pull_en && vbus_present && (s_d.speed == udc_pkg::UDC_LOW_SPEED);
    // level interrupt leaves a flop, so no glitch reaches the pin
    s_d.irq   = |(s_d.int_sts & s_d.int_en);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q        <= '0;
      // enables wake up with every source but suspend
      s_q.int_en <= `UDC_INT_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // bank data already come out of a register, so this only selects flops
  assign reg_rdata          = s_q.bank_sel ? bank_rdata : s_q.rdata;
  assign pullup_dplus       = s_q.pu_dp;
  assign pullup_dminus      = s_q.pu_dm;
  assign transceiver_enable = s_q.xcvr_en;
  assign phy_test_select    = s_q.tst;
  assign suspend_mode       = s_q.susp_mode;
  assign match_address      = s_q.fa_eff;
  assign fifo_flush         = s_q.flush;
  assign ep_index           = s_q.index;
  assign irq                = s_q.irq;

  // checks sleep through srst and all run on the one system clock
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence bus_evt_s;
    bus_reset_det && !soft_rst;
  endsequence

  sequence bank_read_s;
    in_bank_rd && !bank_clr && !in_bank_wr;
  endsequence

  // steps of the address flow, shared by the checks below
  sequence addr_write_s;
    wr_fa && !soft_rst && !bus_reset_det;
  endsequence

  sequence addr_apply_s;
    s_q.pend && transfer_end && !wr_fa && !soft_rst && !bus_reset_det;
  endsequence

  pullup_power_a: assert property (
    (pullup_dplus || pullup_dminus) |-> s_q.pull_en && $past(vbus_present))
    else $error("pull-up on without enable or bus power");

  pullup_side_a: assert property (
    (pullup_dplus |-> s_q.speed == udc_pkg::UDC_FULL_SPEED)
    and (pullup_dminus |-> s_q.speed == udc_pkg::UDC_LOW_SPEED))
    else $error("pull-up on the wrong line for the speed");

  xcvr_write_a: assert property (
    wr_xc && !soft_rst |=> transceiver_enable == $past(reg_wdata[`UDC_XC_XCVR_EN_BIT]))
    else $error("transceiver enable does not follow write");

  pullup_write_a: assert property (
    wr_xc |=> s_q.pull_en == $past(reg_wdata[`UDC_XC_PULLUP_BIT]))
    else $error("pull-up enable does not follow write");

  speed_write_a: assert property (
    wr_xc |=> s_q.speed == $past(reg_wdata[`UDC_XC_SPEED_BIT]))
    else $error("speed select does not follow write");

  line_read_a: assert property (
    reg_rd && reg_addr == `UDC_OFS_XCVR_CTRL
    |=> reg_rdata[`UDC_XC_DPLUS_BIT] == $past(dplus_level) && reg_rdata[`UDC_XC_DMINUS_BIT] == $past(dminus_level))
    else $error("line level bits wrong");

  diff_off_a: assert property (
    reg_rd && reg_addr == `UDC_OFS_XCVR_CTRL && !s_q.xcvr_en |=> !reg_rdata[`UDC_XC_DIFF_BIT])
    else $error("differential state shown with the transceiver off");

  addr_store_a: assert property (
    addr_write_s ##1 reg_rd && reg_addr == `UDC_OFS_FUNC_ADDR
    |=> reg_rdata == {1'b1, $past(reg_wdata[6:0], 2)})
    else $error("written address not read back with pending");

  addr_hold_a: assert property (
    s_q.pend && !transfer_end && !bus_reset_det && !soft_rst |=> $stable(match_address))
    else $error("address changed before transfer end");

  pend_set_a: assert property (
    addr_write_s |=> s_q.pend && s_q.fa_wr == $past(reg_wdata[6:0]))
    else $error("pending not set by address write");

  addr_keep_a: assert property (
    addr_write_s |=> $stable(match_address))
    else $error("address write changed the matching address at once");

  addr_apply_a: assert property (
    addr_apply_s |=> !s_q.pend && match_address == $past(s_q.fa_wr))
    else $error("address not applied at transfer end");

  bus_reset_a: assert property (
    bus_evt_s |=> s_q.rst_flag && match_address == 7'h00 && fifo_flush && ep_index == 4'h0
                  && s_q.int_en == `UDC_INT_EN_BUSRST && irq ##1 !fifo_flush || $past(bus_reset_det))
    else $error("bus reset sequence incomplete");

  addr_zero_a: assert property (
    bus_evt_s |=> s_q.fa_wr == 7'h00 && !s_q.pend)
    else $error("bus reset left an address or pending flag");

  flush_pulse_a: assert property (
    fifo_flush |-> $past(bus_reset_det))
    else $error("fifo flush without bus reset");

  rst_flag_hold_a: assert property (
    s_q.rst_flag && !soft_rst |=> s_q.rst_flag)
    else $error("bus-reset flag dropped without soft reset");

  int_flags_a: assert property (
    bus_evt_s |=> s_q.int_sts[`UDC_INT_RST_BIT] && !s_q.int_sts[`UDC_INT_XFER_BIT]
                  && !s_q.int_sts[`UDC_INT_SUSP_BIT])
    else $error("interrupt flags wrong after bus reset");

  csr_clear_a: assert property (
    bus_evt_s ##1 bank_read_s |=> reg_rdata == 8'h00)
    else $error("endpoint status not cleared by bus reset");

  soft_reset_a: assert property (
    soft_rst && !bus_reset_det |=> s_q.int_en == `UDC_INT_EN_RST && s_q.fa_wr == 7'h00
                                   && !s_q.rst_flag && !transceiver_enable && !irq)
    else $error("soft reset left a register off default");

  soft_addr_a: assert property (
    soft_rst |=> match_address == 7'h00 && !s_q.pend && !suspend_mode
                 && !pullup_dplus && !pullup_dminus)
    else $error("soft reset left address, suspend or pull-up on");

  suspend_a: assert property (
    suspend_det && s_q.susp_en && !soft_rst && !bus_reset_det
    |=> suspend_mode && s_q.int_sts[`UDC_INT_SUSP_BIT])
    else $error("suspend not entered");

  suspend_off_a: assert property (
    suspend_det && !s_q.susp_en && !suspend_mode |=> !suspend_mode)
    else $error("suspend entered with detection off");

  suspend_irq_a: assert property (
    suspend_det && s_q.susp_en && s_q.int_en[`UDC_INT_SUSP_BIT] && !soft_rst && !bus_reset_det
    && !(reg_wr && reg_addr == `UDC_OFS_INT_EN) |=> irq)
    else $error("suspend interrupt not raised");

endmodule
`default_nettype wire

// ### rtl/udc_defs.svh
// address map, field positions and reset values of the usb device control block
`ifndef UDC_DEFS_SVH
`define UDC_DEFS_SVH

`define UDC_ADDR_W          8
`define UDC_DATA_W          8

`define UDC_OFS_FUNC_ADDR   8'h00
`define UDC_OFS_POWER       8'h01
`define UDC_OFS_INT_STS     8'h02
`define UDC_OFS_INT_EN      8'h03
`define UDC_OFS_INDEX       8'h0e
`define UDC_OFS_CSR_BASE    8'h11
`define UDC_CSR_COUNT       5
`define UDC_OFS_XCVR_CTRL   8'hd7

`define UDC_FA_PEND_BIT     7
`define UDC_XC_PULLUP_BIT   7
`define UDC_XC_XCVR_EN_BIT  6
`define UDC_XC_SPEED_BIT    5
`define UDC_XC_TST_HI       4
`define UDC_XC_TST_LO       3
`define UDC_XC_DIFF_BIT     2
`define UDC_XC_DPLUS_BIT    1
`define UDC_XC_DMINUS_BIT   0
`define UDC_PW_SUSP_EN_BIT  0
`define UDC_PW_SUSP_BIT     1
`define UDC_PW_BUSRST_BIT   3

`define UDC_INT_SUSP_BIT    0
`define UDC_INT_XFER_BIT    1
`define UDC_INT_RST_BIT     2
`define UDC_INT_W           3
`define UDC_INT_EN_RST      3'h6
`define UDC_INT_EN_BUSRST   3'h6

`endif

// ### rtl/udc_pkg.sv
// types shared by the usb device control block
package udc_pkg;

  typedef enum logic {
    UDC_LOW_SPEED  = 1'b0,
    UDC_FULL_SPEED = 1'b1
  } udc_speed_t;

  typedef struct packed {
    logic [6:0] fa_wr;
    logic       pend;
    logic [6:0] fa_eff;
    logic       pull_en;
    logic       xcvr_en;
    udc_speed_t speed;
    logic [1:0] tst;
    logic       susp_en;
    logic       susp_mode;
    logic       rst_flag;
    logic [2:0] int_sts;
    logic [2:0] int_en;
    logic [3:0] index;
    logic [7:0] rdata;
    logic       bank_sel;
    logic       flush;
    logic       pu_dp;
    logic       pu_dm;
    logic       irq;
  } udc_state_t;

endpackage

// ### rtl/udc_csr_bank.sv
// small bank of endpoint control/status bytes with registered read and bulk clear
`timescale 1ns/100ps
`default_nettype none
module udc_csr_bank #(
  parameter int DEPTH = 5,
  parameter int AW    = 3
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          clr,
  input  wire logic          wr,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            rd;
  } udc_bank_t;

  udc_bank_t b_q;
  udc_bank_t b_d;

  always_comb begin
    b_d    = b_q;
    b_d.rd = (int'(raddr) < DEPTH) ? b_q.mem[raddr] : 8'h00;
    if (clr) begin
      b_d.mem = '0;
    end else if (wr && int'(waddr) < DEPTH) begin
      b_d.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

  assign rdata = b_q.rd;

endmodule
`default_nettype wire

// ### bench/udc_host_model.sv
// host side model: bus events, bus power and idle line levels
`timescale 1ns/100ps
`default_nettype none
module udc_host_model (
  input  wire logic clk,
  input  wire logic pullup_dplus,
  input  wire logic pullup_dminus,
  output logic      vbus_present,
  output logic      dplus_level,
  output logic      dminus_level,
  output logic      bus_reset_det,
  output logic      suspend_det,
  output logic      transfer_end
);
  logic line_own;
  logic dp_drv;
  logic dm_drv;

  // idle bus: the line with the pull-up reads high, the other sits at its pull-down;
  // while the host owns the lines it drives both levels itself
  assign dplus_level  = line_own ? dp_drv : pullup_dplus;
  assign dminus_level = line_own ? dm_drv : pullup_dminus;

  initial begin
    vbus_present  = 1'b1;
    bus_reset_det = 1'b0;
    suspend_det   = 1'b0;
    transfer_end  = 1'b0;
    line_own      = 1'b0;
    dp_drv        = 1'b0;
    dm_drv        = 1'b0;
  end

  task automatic set_vbus(input logic v);
    @(posedge clk);
    vbus_present <= v;
  endtask

  // host takes or releases both lines right after an edge
  task automatic set_lines(input logic own, input logic dp, input logic dm);
    @(posedge clk);
    line_own <= own;
    dp_drv   <= dp;
    dm_drv   <= dm;
  endtask

  // one-cycle event; returns once the block has taken it
  task automatic pulse(input int kind);
    @(posedge clk);
    bus_reset_det <= (kind == 0);
    suspend_det   <= (kind == 1);
    transfer_end  <= (kind >= 2);
    @(posedge clk);
    bus_reset_det <= 1'b0;
    suspend_det   <= 1'b0;
    transfer_end  <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking testbench of the usb device control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic       clk, srst, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       vbus_present, dplus_level, dminus_level;
  logic       bus_reset_det, suspend_det, transfer_end;
  logic       pullup_dplus, pullup_dminus, transceiver_enable;
  logic       suspend_mode, fifo_flush, irq;
  logic [1:0] phy_test_select;
  logic [6:0] match_address;
  logic [3:0] ep_index;
  int         num_errors, tests_run;

  udc_ctl udc_ctl_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vbus_present(vbus_present),
    .dplus_level(dplus_level), .dminus_level(dminus_level), .bus_reset_det(bus_reset_det),
    .suspend_det(suspend_det), .transfer_end(transfer_end), .pullup_dplus(pullup_dplus),
    .pullup_dminus(pullup_dminus), .transceiver_enable(transceiver_enable),
    .phy_test_select(phy_test_select), .suspend_mode(suspend_mode),
    .match_address(match_address), .fifo_flush(fifo_flush), .ep_index(ep_index), .irq(irq));

  udc_host_model udc_host_model_i (.clk(clk), .pullup_dplus(pullup_dplus),
    .pullup_dminus(pullup_dminus), .vbus_present(vbus_present), .dplus_level(dplus_level),
    .dminus_level(dminus_level), .bus_reset_det(bus_reset_det), .suspend_det(suspend_det),
    .transfer_end(transfer_end));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic t_defaults();
    rd_chk(8'h00, 8'h00);
    rd_chk(8'hd7, 8'h00);
    rd_chk(8'h03, 8'h06);
    rd_chk(8'h40, 8'h00);
  endtask

  task automatic t_xcvr();
    logic s;
    for (int i = 0; i < 2; i++) begin
      s = i[0];
      // read-only low bits written as ones must not stick
      wr(8'hd7, {2'b11, s, s, s, 3'b111});
      tick(2);
      chk({6'h00, pullup_dplus, pullup_dminus}, {6'h00, s, ~s});
      chk({7'h00, transceiver_enable}, 8'h01);
      chk({6'h00, phy_test_select}, {6'h00, s, s});
      rd_chk(8'hd7, {2'b11, s, s, s, s, s, ~s});
    end
    // host drives the lines against the pull-up
    udc_host_model_i.set_lines(1'b1, 1'b0, 1'b1);
    rd_chk(8'hd7, 8'hf9);
    udc_host_model_i.set_lines(1'b1, 1'b1, 1'b1);
    rd_chk(8'hd7, 8'hfb);
    udc_host_model_i.set_lines(1'b0, 1'b0, 1'b0);
    udc_host_model_i.set_vbus(1'b0);
    tick(2);
    chk({6'h00, pullup_dplus, pullup_dminus}, 8'h00);
    udc_host_model_i.set_vbus(1'b1);
    wr(8'hd7, 8'h20);
    tick(2);
    chk({6'h00, pullup_dplus, pullup_dminus}, 8'h00);
    chk({7'h00, transceiver_enable}, 8'h00);
  endtask

  task automatic t_addr();
    wr(8'h00, 8'h05);
    rd_chk(8'h00, 8'h85);
    chk({1'b0, match_address}, 8'h00);
    udc_host_model_i.pulse(2);
    chk({1'b0, match_address}, 8'h05);
    rd_chk(8'h00, 8'h05);
    wr(8'h00, 8'hff);
    wr(8'h00, 8'h2a);
    rd_chk(8'h00, 8'haa);
    chk({1'b0, match_address}, 8'h05);
    udc_host_model_i.pulse(2);
    chk({1'b0, match_address}, 8'h2a);
    udc_host_model_i.pulse(2);
    chk({1'b0, match_address}, 8'h2a);
  endtask

  task automatic t_bus_reset();
    wr(8'h0e, 8'h09);
    #1 chk({4'h0, ep_index}, 8'h09);
    for (int i = 0; i < 5; i++) wr(8'h11 + i[7:0], 8'h3c);
    rd_chk(8'h13, 8'h3c);
    wr(8'h03, 8'h00);
    wr(8'h00, 8'h33);
    udc_host_model_i.pulse(0);
    chk({7'h00, fifo_flush}, 8'h01);
    chk({1'b0, match_address}, 8'h00);
    chk({4'h0, ep_index}, 8'h00);
    chk({7'h00, irq}, 8'h01);
    tick(1);
    chk({7'h00, fifo_flush}, 8'h00);
    rd_chk(8'h01, 8'h08);
    rd_chk(8'h00, 8'h00);
    for (int i = 0; i < 5; i++) rd_chk(8'h11 + i[7:0], 8'h00);
    rd_chk(8'h03, 8'h06);
    rd_chk(8'h02, 8'h04);
    wr(8'h03, 8'h00);
    tick(1);
    chk({7'h00, irq}, 8'h00);
    wr(8'h03, 8'h04);
    tick(1);
    chk({7'h00, irq}, 8'h01);
    wr(8'h02, 8'h04);
    tick(1);
    chk({7'h00, irq}, 8'h00);
  endtask

  task automatic t_suspend();
    udc_host_model_i.pulse(1);
    chk({7'h00, suspend_mode}, 8'h00);
    rd_chk(8'h02, 8'h00);
    wr(8'h01, 8'h01);
    wr(8'h03, 8'h01);
    udc_host_model_i.pulse(1);
    chk({7'h00, suspend_mode}, 8'h01);
    tick(1);
    chk({7'h00, irq}, 8'h01);
    rd_chk(8'h01, 8'h0b);
    rd_chk(8'h02, 8'h01);
  endtask

  task automatic t_soft_reset();
    wr(8'hd7, 8'hff);
    wr(8'h0e, 8'h05);
    wr(8'h00, 8'h11);
    wr(8'h11, 8'h5a);
    wr(8'h01, 8'h08);
    tick(1);
    chk({7'h00, suspend_mode}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    chk({4'h0, ep_index}, 8'h00);
    chk({7'h00, transceiver_enable}, 8'h00);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'hd7, 8'h00);
    rd_chk(8'h03, 8'h06);
    rd_chk(8'h11, 8'h00);
  endtask

  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    srst       = 1'b1;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    num_errors = 0;
    tests_run  = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    tick(1);
    t_defaults();
    t_xcvr();
    t_addr();
    t_bus_reset();
    t_suspend();
    t_soft_reset();
    end_sim();
  end

  // whole run is under 150 cycles; this leaves wide margin
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
